/* inc/mac_cfg.svh */
// constants for the mode based access checker
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH
// wishbone register byte offsets
`define MAC_OFF_EXB_LO 8'h00
`define MAC_OFF_EXB_HI 8'h04
`define MAC_OFF_EXS_LO 8'h08
`define MAC_OFF_EXS_HI 8'h0C
`define MAC_OFF_FWC_LO 8'h10
`define MAC_OFF_FWC_HI 8'h14
`define MAC_OFF_STP 8'h18
`define MAC_OFF_OPT 8'h1C
`define MAC_OFF_STAT 8'h20
`define MAC_OFF_SEG_IDX 8'h24
`define MAC_OFF_SEG_DAT 8'h28
// reset values
`define MAC_RST_BYTE 8'h00
`define MAC_RST_STP 16'h0000
`define MAC_RST_OPT 3'h0
// option bit positions
`define MAC_OPT_EE_NO_ROM 0
`define MAC_OPT_CE_NO_ROM 1
`define MAC_OPT_CE_NO_EE 2
// segment entry layout: r w x in [2:0], hw rights [10:3]
`define MAC_SEG_R 0
`define MAC_SEG_W 1
`define MAC_SEG_X 2
`define MAC_SEG_HW_LO 3
`define MAC_SEG_HW_HI 10
`define MAC_SEG_W_BITS 11
`define MAC_SEG_CNT 64
// security row window within application eeprom, word index
`define MAC_SECROW_LO 16'hFF00
`endif

/* inc/mac_pkg.sv */
// types for the mode based access checker
package mac_pkg;
   typedef enum logic [2:0] {
      MAC_BOOT = 3'h0,
      MAC_TEST = 3'h1,
      MAC_FW = 3'h2,
      MAC_SYS = 3'h3,
      MAC_USER = 3'h4
   } mac_mode_t;
   typedef enum logic [1:0] {
      MAC_ROM = 2'h0,
      MAC_EE = 2'h1,
      MAC_RAM = 2'h2,
      MAC_CXRAM = 2'h3
   } mac_mem_t;
   typedef enum logic [2:0] {
      MAC_G_SEGCFG = 3'h0,
      MAC_G_SYSMGT = 3'h1,
      MAC_G_FWCFG = 3'h2,
      MAC_G_FWOS = 3'h3,
      MAC_G_TEST = 3'h4,
      MAC_G_HW = 3'h5,
      MAC_G_CPU = 3'h6,
      MAC_G_CPUB = 3'h7
   } mac_grp_t;
   typedef enum logic [2:0] {
      MAC_S_NONE = 3'h0,
      MAC_S_CSR = 3'h1,
      MAC_S_CLKSEL = 3'h2,
      MAC_S_PTR2 = 3'h3,
      MAC_S_RNG = 3'h4,
      MAC_S_KEY = 3'h5
   } mac_spec_t;
endpackage : mac_pkg

/* verilog/mac_checker.sv */
// mode based access checker for memory and special register accesses
// Overview of operation
// - system mode full application memory rights
// - user rom checked: none, r, rx
// - user eeprom checked: none, rw, rwx
// - user ram checked: none, rw, rwx
// - firmware gets exchange window in ram
// - boot or firmware reads security rows
// - firmware called from system gets eeprom rw
// - coprocessor always reads writes its ram
// - three options deny rom/eeprom reads
// - boot denied test, segcfg, banked cpu
// - test denied segcfg, banked cpu
// - firmware hw register rights via firewall control
// - system gets segcfg, sysmgt, fwcfg, hw
// - user hw access from segment rights
// - copy engine keeps its start mode
// - general cpu registers open, banked sys/user
// - cpu status readable in firmware, user
// - clock select readable in firmware always
// - segcfg denied outside system mode
// - banked cpu denied in boot, test, fw
// - second table pointer never readable
// - random output read-only, keys unreadable
// - refused register access raises exception
// - table holds up to 64 segments
// - table pointer resets to zero
`timescale 1ns/1ps
`include "mac_cfg.svh"
module mac_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // cpu state
   input wire logic [2:0] cpu_mode_i,
   input wire logic fw_from_sys_i,
   input wire logic [5:0] cur_seg_i,
   input wire logic fetch_from_ee_i,
   // memory access request
   input wire logic mem_req_i,
   input wire logic [1:0] mem_kind_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic mem_ex_i,
   input wire logic mem_from_ce_i,
   input wire logic mem_from_pk_i,
   input wire logic [5:0] mem_seg_i,
   output logic mem_grant_o,
   // copy engine start
   input wire logic ce_start_i,
   input wire logic ce_busy_i,
   // register access request
   input wire logic reg_req_i,
   input wire logic [2:0] reg_grp_i,
   input wire logic [2:0] reg_spec_i,
   input wire logic [2:0] reg_hw_idx_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic reg_from_ce_i,
   output logic reg_grant_o,
   output logic reg_rdata_block_o,
   output logic exception_o
);
   logic [7:0] exb_lo_reg;
   logic [7:0] exb_hi_reg;
   logic [7:0] exs_lo_reg;
   logic [7:0] exs_hi_reg;
   logic [7:0] fwc_lo_reg;
   logic [7:0] fwc_hi_reg;
   logic [15:0] stp_reg;
   logic [2:0] opt_reg;
   logic [5:0] seg_idx_reg;
   logic [`MAC_SEG_W_BITS-1:0] seg_reg [`MAC_SEG_CNT];
   logic [2:0] ce_mode_reg;
   logic [31:0] deny_cnt_reg;
   logic [31:0] rd_next;
   logic wb_req;
   logic wb_wr;

   // a null pointer counts as an empty table
   function automatic logic [`MAC_SEG_W_BITS-1:0] seg_get(
      input logic [5:0] idx);
      seg_get = (stp_reg == `MAC_RST_STP) ? '0 : seg_reg[idx];
   endfunction : seg_get

   function automatic logic in_window(input logic [15:0] a);
      logic [15:0] base;
      logic [16:0] top;
      base = {exb_hi_reg, exb_lo_reg};
      top = {1'b0, base} + {1'b0, exs_hi_reg, exs_lo_reg};
      in_window = (a >= base) && ({1'b0, a} < top);
   endfunction : in_window

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land on the edge where the master sees ack
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   // wishbone ack, one cycle after strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // firewall and exchange window registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exb_lo_reg <= `MAC_RST_BYTE;
         exb_hi_reg <= `MAC_RST_BYTE;
         exs_lo_reg <= `MAC_RST_BYTE;
         exs_hi_reg <= `MAC_RST_BYTE;
         fwc_lo_reg <= `MAC_RST_BYTE;
         fwc_hi_reg <= `MAC_RST_BYTE;
         opt_reg <= `MAC_RST_OPT;
      end else if (wb_wr && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            `MAC_OFF_EXB_LO: exb_lo_reg <= wb_dat_i[7:0];
            `MAC_OFF_EXB_HI: exb_hi_reg <= wb_dat_i[7:0];
            `MAC_OFF_EXS_LO: exs_lo_reg <= wb_dat_i[7:0];
            `MAC_OFF_EXS_HI: exs_hi_reg <= wb_dat_i[7:0];
            `MAC_OFF_FWC_LO: fwc_lo_reg <= wb_dat_i[7:0];
            `MAC_OFF_FWC_HI: fwc_hi_reg <= wb_dat_i[7:0];
            `MAC_OFF_OPT: opt_reg <= wb_dat_i[2:0];
            default: ;
         endcase
      end
   end

   // table pointer and segment entry index
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stp_reg <= `MAC_RST_STP;
         seg_idx_reg <= 6'h00;
      end else if (wb_wr) begin
         if (wb_adr_i == `MAC_OFF_STP && wb_sel_i[1:0] == 2'b11) begin
            stp_reg <= wb_dat_i[15:0];
         end
         if (wb_adr_i == `MAC_OFF_SEG_IDX && wb_sel_i[0]) begin
            seg_idx_reg <= wb_dat_i[5:0];
         end
      end
   end

   // segment rights table, 64 entries
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `MAC_SEG_CNT; i++) begin
            seg_reg[i] <= '0;
         end
      end else if (wb_wr && wb_adr_i == `MAC_OFF_SEG_DAT
                   && wb_sel_i[1:0] == 2'b11) begin
         seg_reg[seg_idx_reg] <= wb_dat_i[`MAC_SEG_W_BITS-1:0];
      end
   end

   // copy engine mode latched at start
   // only an idle start latches, so later mode changes are ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ce_mode_reg <= mac_pkg::MAC_BOOT;
      end else if (ce_start_i && !ce_busy_i) begin
         ce_mode_reg <= cpu_mode_i;
      end
   end

   // memory decision
   logic [2:0] m_mode;
   logic [`MAC_SEG_W_BITS-1:0] m_seg;
   logic m_ok;
   always_comb begin
      m_mode = mem_from_ce_i ? ce_mode_reg : cpu_mode_i;
      m_seg = seg_get(mem_seg_i);
      m_ok = 1'b0;
      unique case (m_mode)
         mac_pkg::MAC_SYS: begin
            if (mem_kind_i == mac_pkg::MAC_ROM) begin
               m_ok = !mem_wr_i;
            end else begin
               m_ok = 1'b1;
            end
         end
         mac_pkg::MAC_USER: begin
            unique case (mem_kind_i)
               mac_pkg::MAC_ROM: m_ok = !mem_wr_i
                  && (!mem_rd_i || m_seg[`MAC_SEG_R])
                  && (!mem_ex_i || (m_seg[`MAC_SEG_X]
                      && m_seg[`MAC_SEG_R]));
               default: m_ok = (!mem_rd_i || m_seg[`MAC_SEG_R])
                  && (!mem_wr_i || m_seg[`MAC_SEG_W])
                  && (!mem_ex_i || (m_seg[`MAC_SEG_X]
                      && m_seg[`MAC_SEG_W]));
            endcase
         end
         mac_pkg::MAC_FW: begin
            if (mem_kind_i != mac_pkg::MAC_ROM && mem_kind_i
                != mac_pkg::MAC_EE && !mem_ex_i
                && in_window(mem_addr_i)) begin
               m_ok = 1'b1;
            end
            if (mem_kind_i == mac_pkg::MAC_EE && fw_from_sys_i
                && !mem_ex_i) begin
               m_ok = 1'b1;
            end
         end
         default: m_ok = 1'b0;
      endcase
      // extra grants and option vetoes after the mode decision
      if ((m_mode == mac_pkg::MAC_BOOT || m_mode == mac_pkg::MAC_FW)
          && mem_kind_i == mac_pkg::MAC_EE && mem_rd_i && !mem_wr_i
          && !mem_ex_i && mem_addr_i >= `MAC_SECROW_LO) begin
         m_ok = 1'b1;
      end
      if (mem_rd_i && mem_kind_i == mac_pkg::MAC_ROM) begin
         if (opt_reg[`MAC_OPT_EE_NO_ROM] && fetch_from_ee_i
             && !mem_from_ce_i) begin
            m_ok = 1'b0;
         end
         if (opt_reg[`MAC_OPT_CE_NO_ROM] && mem_from_ce_i) begin
            m_ok = 1'b0;
         end
      end
      if (mem_rd_i && mem_kind_i == mac_pkg::MAC_EE
          && opt_reg[`MAC_OPT_CE_NO_EE] && mem_from_ce_i) begin
         m_ok = 1'b0;
      end
      // coprocessor grant last, no option can veto it
      if (mem_from_pk_i && mem_kind_i == mac_pkg::MAC_CXRAM
          && !mem_ex_i) begin
         m_ok = 1'b1;
      end
   end
   assign mem_grant_o = mem_req_i && m_ok;

   // register decision
   logic [2:0] r_mode;
   logic [`MAC_SEG_W_BITS-1:0] r_seg;
   logic [15:0] fwc;
   logic r_ok;
   always_comb begin
      r_mode = reg_from_ce_i ? ce_mode_reg : cpu_mode_i;
      r_seg = seg_get(cur_seg_i);
      fwc = {fwc_hi_reg, fwc_lo_reg};
      r_ok = 1'b0;
      unique case (reg_grp_i)
         mac_pkg::MAC_G_SEGCFG: r_ok = r_mode == mac_pkg::MAC_SYS;
         mac_pkg::MAC_G_CPU: r_ok = 1'b1;
         mac_pkg::MAC_G_CPUB: r_ok = r_mode == mac_pkg::MAC_SYS
            || r_mode == mac_pkg::MAC_USER;
         mac_pkg::MAC_G_TEST: r_ok = r_mode == mac_pkg::MAC_TEST;
         mac_pkg::MAC_G_FWCFG: r_ok = r_mode == mac_pkg::MAC_BOOT
            || r_mode == mac_pkg::MAC_TEST || r_mode == mac_pkg::MAC_SYS
            || (r_mode == mac_pkg::MAC_FW && !reg_wr_i);
         mac_pkg::MAC_G_FWOS: r_ok = r_mode == mac_pkg::MAC_BOOT
            || r_mode == mac_pkg::MAC_TEST
            || r_mode == mac_pkg::MAC_FW;
         mac_pkg::MAC_G_SYSMGT: r_ok = r_mode == mac_pkg::MAC_BOOT
            || r_mode == mac_pkg::MAC_TEST
            || r_mode == mac_pkg::MAC_SYS;
         default: begin
            unique case (r_mode)
               mac_pkg::MAC_FW: r_ok = fwc[{1'b0, reg_hw_idx_i}
                  + (reg_wr_i ? 4'h8 : 4'h0)];
               mac_pkg::MAC_USER: r_ok = r_seg[`MAC_SEG_HW_LO
                  + {29'h0, reg_hw_idx_i}];
               default: r_ok = 1'b1;
            endcase
         end
      endcase
      // single-register overrides after the group decision
      if (reg_spec_i == mac_pkg::MAC_S_CSR && !reg_wr_i
          && (r_mode == mac_pkg::MAC_FW
              || r_mode == mac_pkg::MAC_USER)) begin
         r_ok = 1'b1;
      end
      if (reg_spec_i == mac_pkg::MAC_S_CLKSEL && !reg_wr_i
          && r_mode == mac_pkg::MAC_FW) begin
         r_ok = 1'b1;
      end
      if (reg_spec_i == mac_pkg::MAC_S_PTR2 && reg_rd_i) begin
         r_ok = 1'b0;
      end
      if (reg_spec_i == mac_pkg::MAC_S_RNG && reg_wr_i) begin
         r_ok = 1'b0;
      end
      if (reg_spec_i == mac_pkg::MAC_S_KEY && reg_rd_i) begin
         r_ok = 1'b0;
      end
   end
   assign reg_grant_o = reg_req_i && r_ok;
   assign reg_rdata_block_o = reg_req_i && reg_rd_i && !r_ok;
   assign exception_o = reg_req_i && !r_ok;

   // refused access count for software
   // wraps silently at full scale
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         deny_cnt_reg <= 32'h0000_0000;
      end else if ((reg_req_i && !r_ok) || (mem_req_i && !m_ok)) begin
         deny_cnt_reg <= deny_cnt_reg + 32'h0000_0001;
      end
   end

   // read mux
   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (wb_adr_i)
         `MAC_OFF_EXB_LO: rd_next = {24'h00_0000, exb_lo_reg};
         `MAC_OFF_EXB_HI: rd_next = {24'h00_0000, exb_hi_reg};
         `MAC_OFF_EXS_LO: rd_next = {24'h00_0000, exs_lo_reg};
         `MAC_OFF_EXS_HI: rd_next = {24'h00_0000, exs_hi_reg};
         `MAC_OFF_FWC_LO: rd_next = {24'h00_0000, fwc_lo_reg};
         `MAC_OFF_FWC_HI: rd_next = {24'h00_0000, fwc_hi_reg};
         `MAC_OFF_STP: rd_next = {16'h0000, stp_reg};
         `MAC_OFF_OPT: rd_next = {29'h0000_0000, opt_reg};
         `MAC_OFF_STAT: rd_next = deny_cnt_reg;
         `MAC_OFF_SEG_IDX: rd_next = {26'h000_0000, seg_idx_reg};
         `MAC_OFF_SEG_DAT: rd_next = {21'h00_0000, seg_reg[seg_idx_reg]};
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // read data captured on the taking edge, held until the next read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         wb_dat_o <= rd_next;
      end
   end
endmodule : mac_checker

/* bench/mac_checker_asserts.sv */
// port assertions for the access checker
`timescale 1ns/1ps
module mac_checker_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [2:0] cpu_mode_i,
   input wire logic fetch_from_ee_i,
   input wire logic mem_req_i,
   input wire logic [1:0] mem_kind_i,
   input wire logic mem_wr_i,
   input wire logic mem_ex_i,
   input wire logic mem_from_ce_i,
   input wire logic mem_from_pk_i,
   input wire logic mem_grant_o,
   input wire logic reg_req_i,
   input wire logic [2:0] reg_grp_i,
   input wire logic [2:0] reg_spec_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic reg_from_ce_i,
   input wire logic reg_grant_o,
   input wire logic exception_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire cpu = reg_req_i && !reg_from_ce_i;
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack not a single cycle pulse");
   property p_exc;
      exception_o == (reg_req_i && !reg_grant_o);
   endproperty
   a_exc: assert property (p_exc)
      else $error("exception does not match refusal");
   property p_seg;
      cpu && reg_grp_i == 3'h0 && cpu_mode_i != 3'h3 |-> !reg_grant_o;
   endproperty
   a_seg: assert property (p_seg)
      else $error("segment config granted outside system mode");
   property p_cpub;
      cpu && reg_grp_i == 3'h7 && cpu_mode_i < 3'h3 |-> !reg_grant_o;
   endproperty
   a_cpub: assert property (p_cpub)
      else $error("banked cpu granted in boot test or fw");
   property p_ptr2;
      reg_req_i && reg_rd_i && reg_spec_i == 3'h3 |-> !reg_grant_o;
   endproperty
   a_ptr2: assert property (p_ptr2)
      else $error("pointer two read granted");
   property p_rng;
      reg_req_i && reg_wr_i && reg_spec_i == 3'h4 |-> !reg_grant_o;
   endproperty
   a_rng: assert property (p_rng)
      else $error("random output write granted");
   property p_gen;
      cpu && reg_grp_i == 3'h6 |-> reg_grant_o;
   endproperty
   a_gen: assert property (p_gen)
      else $error("general cpu register refused");
   property p_pk;
      mem_req_i && mem_from_pk_i && mem_kind_i == 2'h3 && !mem_ex_i
         |-> mem_grant_o;
   endproperty
   a_pk: assert property (p_pk)
      else $error("coprocessor ram refused to coprocessor");
   property p_rom;
      mem_req_i && cpu_mode_i == 3'h3 && mem_kind_i == 2'h0 && !mem_wr_i
         && !mem_from_ce_i && !mem_from_pk_i && !fetch_from_ee_i
         |-> mem_grant_o;
   endproperty
   a_rom: assert property (p_rom)
      else $error("system rom read or execute refused");
   c_ack: cover property (wb_ack_o);
   c_exc: cover property (exception_o);
   c_mem: cover property (mem_req_i && mem_grant_o);
endmodule : mac_checker_asserts

/* bench/mac_cpu_model.sv */
// copy engine side: start pulse, then busy for LEN cycles
`timescale 1ns/1ps
module mac_cpu_model #(
   parameter int LEN = 40
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   output logic ce_start_o,
   output logic ce_busy_o
);
   int cnt_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ce_start_o <= 1'b0;
      end else begin
         ce_start_o <= go_i && !ce_busy_o && !ce_start_o;
      end
   end
   // busy spans the run so start mode stays in force
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 0;
      end else if (ce_start_o) begin
         cnt_reg <= LEN;
      end else if (cnt_reg > 0) begin
         cnt_reg <= cnt_reg - 1;
      end
   end
   assign ce_busy_o = cnt_reg > 0;
endmodule : mac_cpu_model

/* bench/test_mac_checker.sv */
// self-checking bench for the access checker
`timescale 1ns/1ps
module test_mac_checker;
   typedef struct packed {
      logic [2:0] md;
      logic [2:0] g;
      logic [2:0] s;
      logic [1:0] rw;
      logic e;
   } mac_row_t;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
   logic wb_ack_o, mem_grant_o, reg_grant_o, reg_rdata_block_o;
   logic exception_o, ce_start_i, ce_busy_i, go = 0;
   logic [2:0] cpu_mode_i = '0, reg_grp_i = '0, reg_spec_i = '0;
   logic [2:0] reg_hw_idx_i = '0;
   logic [5:0] cur_seg_i = '0, mem_seg_i = '0;
   logic fw_from_sys_i = 0, fetch_from_ee_i = 0, mem_req_i = 0;
   logic mem_rd_i = 0, mem_wr_i = 0, mem_ex_i = 0, mem_from_ce_i = 0;
   logic mem_from_pk_i = 0, reg_req_i = 0, reg_rd_i = 0, reg_wr_i = 0;
   logic reg_from_ce_i = 0;
   logic [1:0] mem_kind_i = '0;
   logic [15:0] mem_addr_i = '0;
   int err_count = 0, comparisons = 0, cyc = 0;
   // mode, group, special, {rd,wr}, grant
   mac_row_t rows [26] = '{
      '{0,4,0,2,0}, '{0,0,0,2,0}, '{0,7,0,2,0}, '{0,3,0,1,1},
      '{0,6,0,1,1}, '{1,4,0,1,1}, '{1,0,0,1,0}, '{1,7,0,1,0},
      '{2,2,0,2,1}, '{2,2,0,1,0}, '{2,3,0,1,1}, '{2,5,0,2,0},
      '{2,5,2,2,1}, '{2,1,1,2,1}, '{2,7,0,2,0}, '{3,0,0,1,1},
      '{3,1,0,2,1}, '{3,2,0,1,1}, '{3,5,0,1,1}, '{3,7,0,1,1},
      '{3,1,3,2,0}, '{3,5,4,1,0}, '{4,0,0,2,0}, '{4,7,0,1,1},
      '{4,1,1,2,1}, '{4,5,0,2,0}};
   mac_checker dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_mode_i,
      .fw_from_sys_i, .cur_seg_i, .fetch_from_ee_i, .mem_req_i,
      .mem_kind_i, .mem_addr_i, .mem_rd_i, .mem_wr_i, .mem_ex_i,
      .mem_from_ce_i, .mem_from_pk_i, .mem_seg_i, .mem_grant_o,
      .ce_start_i, .ce_busy_i, .reg_req_i, .reg_grp_i, .reg_spec_i,
      .reg_hw_idx_i, .reg_rd_i, .reg_wr_i, .reg_from_ce_i, .reg_grant_o,
      .reg_rdata_block_o, .exception_o);
   mac_cpu_model #(.LEN(40)) u_ce (.clk_i, .rst_i, .go_i(go),
      .ce_start_o(ce_start_i), .ce_busy_o(ce_busy_i));
   always #5 clk_i = ~clk_i;
   task print_verdict();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         print_verdict();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task mchk(input logic [2:0] md, input logic [1:0] k,
      input logic [15:0] a, input logic [2:0] op, input logic e);
      @(posedge clk_i);
      cpu_mode_i <= md;
      mem_req_i <= 1'b1;
      mem_kind_i <= k;
      mem_addr_i <= a;
      {mem_rd_i, mem_wr_i, mem_ex_i} <= op;
      @(posedge clk_i);
      chk(mem_grant_o, e);
   endtask : mchk
   task rchk(input mac_row_t r);
      @(posedge clk_i);
      cpu_mode_i <= r.md;
      reg_req_i <= 1'b1;
      reg_grp_i <= r.g;
      reg_spec_i <= r.s;
      {reg_rd_i, reg_wr_i} <= r.rw;
      @(posedge clk_i);
      chk(reg_grant_o, r.e);
      chk(exception_o, !r.e);
   endtask : rchk
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 8'h18, 0);
      chk(rd, 0);
      wb(0, 8'h2C, 0);
      chk(rd, 0);
      mchk(4, 0, 16'h0000, 3'h4, 0);
      foreach (rows[i]) rchk(rows[i]);
      @(posedge clk_i);
      reg_grp_i <= 3'h5;
      reg_spec_i <= 3'h5;
      cpu_mode_i <= 3'h3;
      {reg_rd_i, reg_wr_i} <= 2'h2;
      @(posedge clk_i);
      chk(reg_grant_o & !reg_rdata_block_o, 0);
      chk(reg_rdata_block_o, 1);
      for (int k = 0; k < 4; k++) begin
         for (int b = 0; b < 3; b++) begin
            mchk(3, k, 16'h0000, 3'h1 << b, !(k == 0 && b == 1));
         end
      end
      wb(1, 8'h18, 32'h0000_0001);
      wb(1, 8'h24, 32'h0000_0005);
      wb(1, 8'h28, 32'h0000_0021);
      wb(1, 8'h24, 32'h0000_0006);
      wb(1, 8'h28, 32'h0000_0003);
      cur_seg_i <= 6'h05;
      mem_seg_i <= 6'h05;
      mchk(4, 0, 16'h0010, 3'h4, 1);
      mchk(4, 0, 16'h0010, 3'h1, 0);
      reg_hw_idx_i <= 3'h2;
      rchk('{4, 5, 0, 2, 1});
      reg_hw_idx_i <= 3'h3;
      rchk('{4, 5, 0, 2, 0});
      mem_seg_i <= 6'h06;
      mchk(4, 1, 16'h0020, 3'h2, 1);
      mchk(4, 1, 16'h0020, 3'h1, 0);
      mchk(4, 2, 16'h0020, 3'h2, 1);
      mchk(4, 2, 16'h0020, 3'h1, 0);
      wb(1, 8'h04, 32'h0000_0001);
      wb(1, 8'h08, 32'h0000_0010);
      mchk(2, 2, 16'h0100, 3'h2, 1);
      mchk(2, 2, 16'h010F, 3'h4, 1);
      mchk(2, 2, 16'h0110, 3'h4, 0);
      mchk(2, 2, 16'h00FF, 3'h4, 0);
      mchk(0, 1, 16'hFF00, 3'h4, 1);
      mchk(2, 1, 16'hFF00, 3'h4, 1);
      mchk(2, 1, 16'h0000, 3'h2, 0);
      fw_from_sys_i <= 1'b1;
      mchk(2, 1, 16'h0000, 3'h2, 1);
      fw_from_sys_i <= 1'b0;
      mem_seg_i <= 6'h05;
      mem_from_pk_i <= 1'b1;
      mchk(4, 3, 16'h0000, 3'h2, 1);
      mem_from_pk_i <= 1'b0;
      wb(1, 8'h10, 32'h0000_0001);
      wb(1, 8'h14, 32'h0000_0002);
      reg_hw_idx_i <= 3'h0;
      rchk('{2, 5, 0, 2, 1});
      rchk('{2, 5, 0, 1, 0});
      reg_hw_idx_i <= 3'h1;
      rchk('{2, 5, 0, 1, 1});
      rchk('{2, 5, 0, 2, 0});
      cpu_mode_i <= 3'h3;
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (3) @(posedge clk_i);
      mem_from_ce_i <= 1'b1;
      mchk(4, 2, 16'h0000, 3'h2, 1);
      reg_from_ce_i <= 1'b1;
      rchk('{4, 0, 0, 2, 1});
      reg_from_ce_i <= 1'b0;
      wb(1, 8'h1C, 32'h0000_0002);
      mchk(4, 0, 16'h0000, 3'h4, 0);
      mchk(4, 1, 16'h0000, 3'h4, 1);
      wb(1, 8'h1C, 32'h0000_0004);
      mchk(4, 1, 16'h0000, 3'h4, 0);
      mem_from_ce_i <= 1'b0;
      wb(1, 8'h1C, 32'h0000_0001);
      fetch_from_ee_i <= 1'b1;
      mchk(3, 0, 16'h0000, 3'h4, 0);
      fetch_from_ee_i <= 1'b0;
      mchk(3, 0, 16'h0000, 3'h4, 1);
      mem_req_i <= 1'b0;
      reg_req_i <= 1'b0;
      reg_grp_i <= 3'h4;
      @(posedge clk_i);
      chk(mem_grant_o, 0);
      chk(reg_grant_o, 0);
      chk(exception_o, 0);
      print_verdict();
   end
endmodule : test_mac_checker
bind mac_checker mac_checker_asserts u_asr (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .cpu_mode_i, .fetch_from_ee_i, .mem_req_i,
   .mem_kind_i, .mem_wr_i, .mem_ex_i, .mem_from_ce_i, .mem_from_pk_i,
   .mem_grant_o, .reg_req_i, .reg_grp_i, .reg_spec_i, .reg_rd_i,
   .reg_wr_i, .reg_from_ce_i, .reg_grant_o, .exception_o);
